// [ast_line_model.sv]
// ast_line_model: remote serial device, receives frames and drives receive line
// assumes the bench gives it the divisor, speed and length in use
`timescale 1ns/10ps

module ast_line_model
(
	// line side
	input  wire logic       clk_i,
	input  wire logic       line_i,
	input  wire logic [7:0] div_i,
	input  wire logic       hs_i,
	input  wire logic       nine_i,
	output logic            line_o
);
	logic [9:0] frames[$];
	logic [9:0] f;
	int         per;

	initial line_o = 1'b1;

	// wait to mid start bit, then mid-bit sampling of data lsb first, stop
	always
	begin
		@(negedge line_i);
		per = (hs_i ? 16 : 64) * (int'(div_i) + 1);
		repeat (per / 2) @(posedge clk_i);
		f = '1;
		for (int i = 0; i < (nine_i ? 10 : 9); i++)
		begin
			repeat (per) @(posedge clk_i);
			f[i] = line_i;
		end
		frames.push_back(f);
	end

	task automatic hold(input logic lvl);
		line_o <= lvl;
	endtask
endmodule

// [ast_pkg.sv]
// ast_pkg: register map, field positions, reset values and timing for the serial transmitter
// assumes a classic wishbone slave with 32-bit data, one aligned word per register
package ast_pkg;

	// register byte addresses
	localparam logic [4:0] ADDR_TX_CTRL   = 5'h00;
	localparam logic [4:0] ADDR_RX_CTRL   = 5'h04;
	localparam logic [4:0] ADDR_HOLD      = 5'h08;
	localparam logic [4:0] ADDR_DIVISOR   = 5'h0c;

	// transmit_control_register fields
	localparam int TXC_NINTH_DATA   = 0;
	localparam int TXC_SHIFT_EMPTY  = 1;
	localparam int TXC_HIGH_SPEED   = 2;
	localparam int TXC_LINK_MODE    = 4;
	localparam int TXC_TX_ENABLE    = 5;
	localparam int TXC_NINE_BIT     = 6;

	// receive_control_register fields
	localparam int RXC_PORT_ENABLE  = 7;

	// flag / enable register fields (interrupt flag and enable share a word)
	localparam logic [4:0] ADDR_FLAG_EN   = 5'h10;
	localparam int FLG_TX_EMPTY     = 4;
	localparam int ENA_TX_IRQ       = 12;

	// reset values
	localparam logic [7:0] TXC_RESET      = 8'h02;
	localparam logic [7:0] DIVISOR_RESET  = 8'h00;

	// oversampling ratios per bit
	localparam int OVS_LOW_SPEED    = 64;
	localparam int OVS_HIGH_SPEED   = 16;
	localparam int RX_OVS           = 16;

	// character length without start/stop
	localparam int DATA_BITS_MAX    = 9;

	// received character as handed to the user side
	typedef struct packed {
		logic       valid;
		logic       ninth;
		logic [7:0] data;
	} ast_rx_char_type;

endpackage

// [ast_serial.sv]
// ast_serial: asynchronous serial transmitter with baud generator and majority-vote receive sampler
// assumes a classic wishbone master on clk_i, and sleep_i driven by the core's power logic
//
// Summary of operation
// - one start, eight/nine data, one stop
// - least significant bit shifted first
// - baud from 8-bit divisor register
// - oversample x16 or x64 by high-speed select
// - transmitter and receiver independent, shared settings
// - no parity; ninth bit is software's
// - sleep halts all serial activity
// - asynchronous only when link mode clear
// - three receive samples, majority decides
// - low speed: samples seven, eight, nine
// - high speed: three edges before x4 edge
// - shifter reloads only after stop bit
// - reload in one cycle, flag then set
// - empty flag read-only, cleared by write
// - interrupt passed only when enable set
// - shifter empty status polled, no interrupt
// - setting transmit enable sets empty flag
// - start needs data and shift clock
// - idle shifter takes written data directly
// - clearing enable aborts, pin goes high-z
// - port enable hands pins to serial port
`timescale 1ns/10ps

module ast_serial
(
	// system
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 sleep_i,
	// wishbone slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [4:0]           adr_i,
	input  wire logic [31:0]          dat_i,
	output logic      [31:0]          dat_o,
	output logic                      ack_o,
	// line pins
	input  wire logic                 receive_pin_i,
	output logic                      transmit_pin_o,
	output logic                      transmit_pin_oe_o,
	// interrupt request and receive sampler result
	output logic                      tx_irq_o,
	output logic                      rx_bit_o,
	output logic                      rx_bit_valid_o
);

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic       nine_bit_select;
	logic       ninth_data_bit;
	logic       high_speed_baud_select;
	logic       link_mode_select;
	logic       transmit_enable;
	logic       serial_port_enable;
	logic       transmit_buffer_irq_enable;
	logic [7:0] baud_divisor_register;
	logic [7:0] transmit_holding_register;
	logic       hold_full;
	logic       transmit_buffer_empty_flag;
	logic       shifter_busy;

	logic       req;
	logic       wr_req;
	logic       active;

	assign req      = cyc_i && stb_i && !ack_o;
	assign wr_req   = req && we_i;
	// serial logic runs only when enabled, asynchronous and awake
	assign active   = serial_port_enable && !link_mode_select && !sleep_i;

	// word decode on byte address bits 4:2; the two low address bits are
	// ignored, so any byte address inside a word selects that word
	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a[4:2] == off[4:2]);
	endfunction

	logic wr_txc;
	logic wr_rxc;
	logic wr_hold;
	logic wr_div;
	logic wr_flg;
	assign wr_txc  = wr_req && sel_i[0] && hit(adr_i, ast_pkg::ADDR_TX_CTRL);
	assign wr_rxc  = wr_req && sel_i[0] && hit(adr_i, ast_pkg::ADDR_RX_CTRL);
	assign wr_hold = wr_req && sel_i[0] && hit(adr_i, ast_pkg::ADDR_HOLD);
	assign wr_div  = wr_req && sel_i[0] && hit(adr_i, ast_pkg::ADDR_DIVISOR);
	assign wr_flg  = wr_req && sel_i[1] && hit(adr_i, ast_pkg::ADDR_FLAG_EN);

	// bus answer: one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= req;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nine_bit_select        <= ast_pkg::TXC_RESET[ast_pkg::TXC_NINE_BIT];
			ninth_data_bit         <= ast_pkg::TXC_RESET[ast_pkg::TXC_NINTH_DATA];
			high_speed_baud_select <= ast_pkg::TXC_RESET[ast_pkg::TXC_HIGH_SPEED];
			link_mode_select       <= ast_pkg::TXC_RESET[ast_pkg::TXC_LINK_MODE];
			transmit_enable        <= ast_pkg::TXC_RESET[ast_pkg::TXC_TX_ENABLE];
		end
		else if (wr_txc)
		begin
			nine_bit_select        <= dat_i[ast_pkg::TXC_NINE_BIT];
			ninth_data_bit         <= dat_i[ast_pkg::TXC_NINTH_DATA];
			high_speed_baud_select <= dat_i[ast_pkg::TXC_HIGH_SPEED];
			link_mode_select       <= dat_i[ast_pkg::TXC_LINK_MODE];
			transmit_enable        <= dat_i[ast_pkg::TXC_TX_ENABLE];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			serial_port_enable <= 1'b0;
		else if (wr_rxc)
			serial_port_enable <= dat_i[ast_pkg::RXC_PORT_ENABLE];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			transmit_buffer_irq_enable <= 1'b0;
		else if (wr_flg)
			transmit_buffer_irq_enable <= dat_i[ast_pkg::ENA_TX_IRQ];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			baud_divisor_register <= ast_pkg::DIVISOR_RESET;
		else if (wr_div)
			baud_divisor_register <= dat_i[7:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// baud generator: one tick per (divisor+1) clocks, then divided by the ratio

	logic [7:0] div_cnt;
	logic       brg_tick;
	logic [5:0] ovs_cnt;
	logic       shift_clk;
	logic [5:0] ovs_last;

	// a new divisor takes effect at the next reload, not in mid-count
	assign brg_tick = active && (div_cnt == 8'h00);
	// bit period = ratio * (divisor + 1) clocks
	assign ovs_last = high_speed_baud_select ? 6'(ast_pkg::OVS_HIGH_SPEED - 1)
	                                         : 6'(ast_pkg::OVS_LOW_SPEED - 1);
	assign shift_clk = brg_tick && (ovs_cnt == ovs_last);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !active)
			div_cnt <= 8'h00;
		else if (div_cnt == 8'h00)
			div_cnt <= baud_divisor_register;
		else
			div_cnt <= div_cnt - 8'h01;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !active)
			ovs_cnt <= 6'h00;
		else if (brg_tick)
			ovs_cnt <= (ovs_cnt >= ovs_last) ? 6'h00 : ovs_cnt + 6'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// transmitter: holding register and shift register

	logic [10:0] shift_reg;
	logic [3:0]  bits_left;
	logic        load_shift;

	// load when shifter idle and holding register full; data written while
	// transmit enable is clear waits here and goes out once it is set
	assign load_shift = active && transmit_enable && hold_full
	                  && !shifter_busy;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			transmit_holding_register <= 8'h00;
			hold_full                 <= 1'b0;
		end
		else if (wr_hold)
		begin
			transmit_holding_register <= dat_i[7:0];
			hold_full                 <= 1'b1;
		end
		else if (load_shift)
			hold_full <= 1'b0;
	end

	// set wins over clear; write of new data clears
	// a holding write in the very cycle of a shifter load leaves the flag set,
	// so software should see the flag set before each holding write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			transmit_buffer_empty_flag <= 1'b1;
		else if (load_shift || (wr_txc && dat_i[ast_pkg::TXC_TX_ENABLE] && !transmit_enable))
			transmit_buffer_empty_flag <= 1'b1;
		else if (wr_hold)
			transmit_buffer_empty_flag <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !transmit_enable || !active)
		begin
			// abort resets the shifter; pin released
			shifter_busy <= 1'b0;
			shift_reg    <= 11'h7ff;
			bits_left    <= 4'h0;
		end
		else if (load_shift)
		begin
			shifter_busy <= 1'b1;
			// stop, optional ninth, data, idle-high lsb; start forced at first shift clock, lsb first
			shift_reg    <= nine_bit_select
			              ? {1'b1, ninth_data_bit, transmit_holding_register, 1'b1}
			              : {2'b11, transmit_holding_register, 1'b1};
			bits_left    <= nine_bit_select ? 4'(ast_pkg::DATA_BITS_MAX + 2)
			                                : 4'(ast_pkg::DATA_BITS_MAX + 1);
		end
		else if (shifter_busy && shift_clk)
		begin
			if (bits_left == 4'h0)
				shifter_busy <= 1'b0;
			else
			begin
				// first shift clock drives the start bit low
				shift_reg <= (bits_left[3:0] == (nine_bit_select ? 4'hb : 4'ha))
				           ? {shift_reg[10:1], 1'b0}
				           : {1'b1, shift_reg[10:1]};
				bits_left <= bits_left - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			transmit_pin_o    <= 1'b1;
			transmit_pin_oe_o <= 1'b0;
		end
		else
		begin
			// pin and enable are registered, one clock behind the shifter
			transmit_pin_o    <= shift_reg[0];
			transmit_pin_oe_o <= serial_port_enable && !link_mode_select && transmit_enable;
		end
	end

	assign tx_irq_o = transmit_buffer_empty_flag && transmit_buffer_irq_enable;

	////////////////////////////////////////////////////////////////////////////
	// receive sampler: x16 phase counter, three samples, majority
	// the sampler is free running and not aligned to a start bit, so rx_bit_o
	// is the line level seen near the middle of each sample period

	logic [3:0] rx_phase;
	logic [2:0] rx_samples;
	logic       rx_tick;
	logic [5:0] rx_ovs;

	// own phase counter, shared divisor and ratio
	assign rx_tick = brg_tick;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !active)
		begin
			rx_ovs   <= 6'h00;
			rx_phase <= 4'h0;
		end
		else if (rx_tick)
		begin
			// at low speed the x64 tick is divided by 4 to give x16 per bit
			rx_ovs   <= (rx_ovs >= ovs_last) ? 6'h00 : rx_ovs + 6'h01;
			rx_phase <= high_speed_baud_select ? rx_ovs[3:0] : rx_ovs[5:2];
		end
	end

	logic take_sample;
	// phases 7,8,9 of sixteen; three edges just before the mid-bit x4 edge
	assign take_sample = rx_tick && (high_speed_baud_select
	                   ? (rx_ovs[3:0] >= 4'h5 && rx_ovs[3:0] <= 4'h7)
	                   : (rx_ovs[1:0] == 2'h3 && rx_phase >= 4'h6 && rx_phase <= 4'h8));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_samples <= 3'h7;
		else if (take_sample)
			rx_samples <= {rx_samples[1:0], receive_pin_i};
	end

	logic last_sample;
	assign last_sample = take_sample && (high_speed_baud_select
	                   ? rx_ovs[3:0] == 4'h7 : rx_phase == 4'h8);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_bit_o       <= 1'b1;
			rx_bit_valid_o <= 1'b0;
		end
		else
		begin
			rx_bit_valid_o <= last_sample;
			if (last_sample)
				rx_bit_o <= (rx_samples[1] & rx_samples[0]) | (rx_samples[1] & receive_pin_i)
				          | (rx_samples[0] & receive_pin_i);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else
		begin
			dat_o <= 32'h0000_0000;
			if (req && !we_i)
			begin
				if (hit(adr_i, ast_pkg::ADDR_TX_CTRL))
				begin
					dat_o[ast_pkg::TXC_NINE_BIT]    <= nine_bit_select;
					dat_o[ast_pkg::TXC_TX_ENABLE]   <= transmit_enable;
					dat_o[ast_pkg::TXC_LINK_MODE]   <= link_mode_select;
					dat_o[ast_pkg::TXC_HIGH_SPEED]  <= high_speed_baud_select;
					dat_o[ast_pkg::TXC_SHIFT_EMPTY] <= !shifter_busy;
					dat_o[ast_pkg::TXC_NINTH_DATA]  <= ninth_data_bit;
				end
				else if (hit(adr_i, ast_pkg::ADDR_RX_CTRL))
					dat_o[ast_pkg::RXC_PORT_ENABLE] <= serial_port_enable;
				else if (hit(adr_i, ast_pkg::ADDR_HOLD))
					dat_o[7:0] <= transmit_holding_register;
				else if (hit(adr_i, ast_pkg::ADDR_DIVISOR))
					dat_o[7:0] <= baud_divisor_register;
				else if (hit(adr_i, ast_pkg::ADDR_FLAG_EN))
				begin
					dat_o[ast_pkg::FLG_TX_EMPTY] <= transmit_buffer_empty_flag;
					dat_o[ast_pkg::ENA_TX_IRQ]   <= transmit_buffer_irq_enable;
				end
			end
		end
	end

endmodule

// [ast_serial_properties.sv]
// ast_serial_properties: port-level checks for the serial transmitter
// assumes binding to ast_serial with the package register offsets
`timescale 1ns/10ps

module ast_serial_properties
(
	// watched ports
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        sleep_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [3:0]  sel_i,
	input wire logic [4:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        transmit_pin_o,
	input wire logic        transmit_pin_oe_o,
	input wire logic        tx_irq_o,
	input wire logic        rx_bit_o,
	input wire logic        rx_bit_valid_o
);
	logic wr_tx;
	logic wr_rx;
	logic oe;

	assign wr_tx = ack_o && we_i && sel_i[0] && adr_i == 5'h00;
	assign wr_rx = ack_o && we_i && sel_i[0] && adr_i == 5'h04;
	assign oe = transmit_pin_oe_o;

	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////
	a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_unmapped_zero: assert property (ack_o && !we_i && adr_i[4:2] > 3'h4 |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_irq_gate: assert property (ack_o && !we_i && adr_i == 5'h10
		|-> tx_irq_o == (dat_o[4] && dat_o[12]))
		else $error("irq differs from flag and enable");
	a_abort_release: assert property (wr_tx && !dat_i[5] |=> ##1 !oe)
		else $error("pin driven after enable cleared");
	a_mode_release: assert property (wr_tx && dat_i[4] |=> ##1 !oe)
		else $error("pin driven in link mode");
	a_port_release: assert property (wr_rx && !dat_i[7] |=> ##1 !oe)
		else $error("pin driven with port disabled");
	a_enable_idle: assert property ($rose(oe) |-> transmit_pin_o)
		else $error("line not idle high at enable");
	a_sleep_pin: assert property (sleep_i [*3] |=> $stable(transmit_pin_o))
		else $error("line moved during sleep");
	a_sleep_sampler: assert property (sleep_i ##1 sleep_i |-> !rx_bit_valid_o)
		else $error("sampler ran during sleep");
	a_valid_pulse: assert property (rx_bit_valid_o |=> !rx_bit_valid_o)
		else $error("sample strobe too long");
endmodule

// [async_serial_transmitter_tb_top.sv]
// async_serial_transmitter_tb_top: register-level tests of the serial transmitter
// assumes ast_serial, the line model and the checker in the same compile
`timescale 1ns/10ps

module async_serial_transmitter_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        sleep_i = 1'b0;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [3:0]  sel_i = 4'h0;
	logic [4:0]  adr_i = 5'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        rxp;
	logic        transmit_pin_o;
	logic        transmit_pin_oe_o;
	logic        tx_irq_o;
	logic        rx_bit_o;
	logic        rx_bit_valid_o;
	logic [31:0] rd;
	logic [7:0]  div_r = 8'h00;
	logic        hs_r = 1'b1;
	logic        nine_r = 1'b0;
	int          n_errors = 0;
	int          checks = 0;
	int          n;
	wire logic   tx_line = transmit_pin_oe_o ? transmit_pin_o : 1'b1;

	ast_serial uut (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .receive_pin_i(rxp), .transmit_pin_o(transmit_pin_o),
		.transmit_pin_oe_o(transmit_pin_oe_o), .tx_irq_o(tx_irq_o), .rx_bit_o(rx_bit_o),
		.rx_bit_valid_o(rx_bit_valid_o));
	ast_line_model model (.clk_i(clk_i), .line_i(tx_line), .div_i(div_r), .hs_i(hs_r),
		.nine_i(nine_r), .line_o(rxp));

	initial
	begin
		forever #10 clk_i = ~clk_i;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(input int lim);
		n++;
		@(posedge clk_i);
		if (n > lim)
		begin
			n_errors++;
			final_report();
		end
	endtask

	// one classic cycle, entered and left just after a rising edge
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		n = 0;
		do tick(50); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask

	task automatic wframes(input int k);
		n = 0;
		while (model.frames.size() < k)
			tick(5000);
	endtask

	task automatic wvalid;
		n = 0;
		do tick(2000); while (rx_bit_valid_o !== 1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdchk("txc reset", 5'h00, {24'h0, ast_pkg::TXC_RESET});
		rdchk("divisor reset", 5'h0c, 32'h0);
		rdchk("flag reset", 5'h10, 32'h0000_0010);
		rdchk("unmapped", 5'h14, 32'h0);
		wb(1'b1, 5'h10, 32'h0);
		rdchk("flag ro", 5'h10, 32'h0000_0010);
		wb(1'b1, 5'h10, 32'h0000_1000);
		chk("irq on", {31'h0, tx_irq_o}, 32'h1);
		rdchk("irq enable", 5'h10, 32'h0000_1010);
		wb(1'b1, 5'h10, 32'h0);
		chk("irq off", {31'h0, tx_irq_o}, 32'h0);
		$display("test registers done");

		wb(1'b1, 5'h0c, 32'h0);
		wb(1'b1, 5'h04, 32'h0000_0080);
		wb(1'b1, 5'h00, 32'h0000_0024);
		rdchk("flag enable", 5'h10, 32'h0000_0010);
		wb(1'b1, 5'h08, 32'h0000_00a5);
		rdchk("flag direct", 5'h10, 32'h0000_0010);
		wb(1'b1, 5'h08, 32'h0000_003c);
		rdchk("flag full", 5'h10, 32'h0);
		rdchk("shifter busy", 5'h00, 32'h0000_0024);
		wframes(2);
		chk("frame 1", {22'h0, model.frames[0]}, 32'h0000_03a5);
		chk("frame 2", {22'h0, model.frames[1]}, 32'h0000_033c);
		repeat (20) @(posedge clk_i);
		rdchk("shifter idle", 5'h00, 32'h0000_0026);
		wb(1'b1, 5'h00, 32'h0000_0065);
		nine_r = 1'b1;
		wb(1'b1, 5'h08, 32'h0000_005a);
		wframes(3);
		chk("nine bit", {22'h0, model.frames[2]}, 32'h0000_035a);
		repeat (20) @(posedge clk_i);
		nine_r = 1'b0;
		$display("test frames done");

		wb(1'b1, 5'h0c, 32'h0000_0002);
		wb(1'b1, 5'h00, 32'h0000_0020);
		div_r = 8'h02;
		hs_r = 1'b0;
		wb(1'b1, 5'h08, 32'h0000_0081);
		n = 0;
		while (tx_line !== 1'b0)
			tick(500);
		n = 0;
		while (tx_line === 1'b0)
			tick(500);
		chk("start width", n, 32'd192);
		wframes(4);
		chk("slow frame", {22'h0, model.frames[3]}, 32'h0000_0381);
		$display("test rate done");

		wb(1'b1, 5'h08, 32'h0);
		repeat (300) @(posedge clk_i);
		wb(1'b1, 5'h00, 32'h0);
		repeat (2) @(posedge clk_i);
		chk("abort oe", {31'h0, transmit_pin_oe_o}, 32'h0);
		repeat (2500) @(posedge clk_i);
		model.frames.delete();
		rdchk("abort status", 5'h00, 32'h0000_0002);
		wb(1'b1, 5'h0c, 32'h0);
		div_r = 8'h00;
		hs_r = 1'b1;
		wb(1'b1, 5'h08, 32'h0000_00c3);
		wb(1'b1, 5'h00, 32'h0000_0024);
		repeat (2) @(posedge clk_i);
		chk("port oe", {31'h0, transmit_pin_oe_o}, 32'h1);
		wframes(1);
		chk("late enable", {22'h0, model.frames[0]}, 32'h0000_03c3);
		wb(1'b1, 5'h00, 32'h0000_0034);
		repeat (2) @(posedge clk_i);
		chk("link oe", {31'h0, transmit_pin_oe_o}, 32'h0);
		wb(1'b1, 5'h00, 32'h0000_0024);
		wb(1'b1, 5'h04, 32'h0);
		repeat (2) @(posedge clk_i);
		chk("port off oe", {31'h0, transmit_pin_oe_o}, 32'h0);
		$display("test abort and modes done");

		// the sampler only runs with the port enabled
		wb(1'b1, 5'h04, 32'h0000_0080);
		model.hold(1'b0);
		wvalid();
		wvalid();
		chk("sample low", {31'h0, rx_bit_o}, 32'h0);
		model.hold(1'b1);
		wvalid();
		wvalid();
		chk("sample high", {31'h0, rx_bit_o}, 32'h1);
		sleep_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		n = 0;
		repeat (60)
		begin
			@(posedge clk_i);
			n += int'(rx_bit_valid_o === 1'b1);
		end
		chk("sleep strobes", n, 32'd0);
		sleep_i <= 1'b0;
		$display("test sampler done");
		final_report();
	end
endmodule

bind ast_serial ast_serial_properties chk_i (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .transmit_pin_o(transmit_pin_o),
	.transmit_pin_oe_o(transmit_pin_oe_o), .tx_irq_o(tx_irq_o), .rx_bit_o(rx_bit_o),
	.rx_bit_valid_o(rx_bit_valid_o));
